// ---- rpto_top.sv ----
// Purpose: Fan shutdown request, remote reset pulse, remote power-off latch and
//          two overtemperature outputs behind a small register port
// Assumes: One 250 MHz clock; auxiliary reset already synchronous to it
// Notes:   Notes on behaviour below
//
// Notes on behaviour
// - Fan off pin follows config bit five
// - Fan run bit resets to one
// - Fan off low overrides any fan speed
// - Remote reset write gives 125 us low
// - Remote reset bit self clears after pulse
// - Remote power-off write latches output high
// - Only power-lost input or auxiliary reset clears power-off
// - Trip after more than three hot samples
// - Release after three samples five below
// - Both thermal outputs share one filter design; A drives low, B is open drain
// - Power lost stops fan, clears power-off
// - Auxiliary reset returns all registers default
`timescale 1ns/1ps
module rpto_top
  import rpto_pkg::*;
(
  input  wire logic            clock,              // System clock, 250 MHz
  input  wire logic            auxiliary_reset_in, // Low resets the block
  input  wire logic [3:0]      reg_addr,           // Register address
  input  wire logic [7:0]      reg_wdata,          // Write data
  input  wire logic            reg_write,          // Write strobe
  input  wire logic            reg_read,           // Read strobe
  output logic      [7:0]      reg_rdata,          // Read data, cycle after strobe
  input  wire logic            power_lost_b,       // Low when main power removed
  input  wire rpto_sample_type sample,             // Temperature measurement
  input  wire logic [7:0]      fan_speed_in,       // Requested fan speed code
  output logic      [7:0]      fan_speed_out,      // Fan speed drive
  output logic                 fan_off_b,          // Low requests fan off
  output logic                 remote_reset_b,     // Low during reset pulse
  output logic                 remote_power_off,   // High while power-off latched
  output logic                 overheat_out_a,     // Low when hot, pulled-up style
  output logic                 overheat_out_b_o,   // Open drain: always drives 0
  output logic                 overheat_out_b_oe   // Open drain enable, high when hot
);

  // ****************************************
  // Reset
  // ****************************************
  logic rst_b;                       // Block reset, low active
  assign rst_b = auxiliary_reset_in;

  // ****************************************
  // State
  // ****************************************
  logic [7:0]  config_reg;           // Configuration register
  logic [7:0]  next_config_reg;
  logic        reset_req;            // Remote reset bit
  logic        next_reset_req;
  logic        power_off;            // Remote power-off bit
  logic        next_power_off;
  logic [7:0]  trip_a;               // Trip limit A
  logic [7:0]  next_trip_a;
  logic [7:0]  trip_b;               // Trip limit B
  logic [7:0]  next_trip_b;
  logic [RPTO_PULSE_CNT_W-1:0] pulse_cnt;      // Cycles left in reset pulse
  logic [RPTO_PULSE_CNT_W-1:0] next_pulse_cnt;
  logic [7:0]  next_rdata;           // Read data mux
  logic [7:0]  next_fan_speed;       // Fan drive next value
  logic [1:0]  hot;                  // Filtered flags per channel
  logic [7:0]  limit [2];            // Trip limit per channel
  logic        wr_config;            // Decoded writes
  logic        wr_remote;

  localparam logic [RPTO_PULSE_CNT_W-1:0] PULSE_LEN =
    RPTO_PULSE_CNT_W'(RPTO_RESET_PULSE_CYC);

  // ****************************************
  // Overtemperature channels
  // ****************************************
  assign limit[0] = trip_a;
  assign limit[1] = trip_b;

  // Same module for both channels, only the driver differs
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_hot
      rpto_overheat u_hot
      (
        .clock  (clock),
        .rst_b  (rst_b),
        .sample (sample),
        .limit  (limit[ch]),
        .hot    (hot[ch])
      );
    end
  endgenerate

  // ****************************************
  // Register writes and control next state
  // ****************************************
  always_comb
  begin
    wr_config       = reg_write && (reg_addr == RPTO_OFF_CONFIG);
    wr_remote       = reg_write && (reg_addr == RPTO_OFF_REMOTE);
    next_config_reg = config_reg;
    next_trip_a     = trip_a;
    next_trip_b     = trip_b;
    next_reset_req  = reset_req;
    next_pulse_cnt  = pulse_cnt;
    next_power_off  = power_off;

    if (wr_config)
      next_config_reg = reg_wdata;
    if (reg_write && (reg_addr == RPTO_OFF_TRIP_A))
      next_trip_a = reg_wdata;
    if (reg_write && (reg_addr == RPTO_OFF_TRIP_B))
      next_trip_b = reg_wdata;

    // Reset pulse countdown; bit drops when the count ends
    if (reset_req)
    begin
      if (pulse_cnt <= 1)
      begin
        next_reset_req = 1'b0;
        next_pulse_cnt = '0;
      end
      else
        next_pulse_cnt = pulse_cnt - 1'b1;
    end
    // A new request while running is ignored; pulse length stays fixed
    else if (wr_remote && reg_wdata[RPTO_REM_RESET])
    begin
      next_reset_req = 1'b1;
      next_pulse_cnt = PULSE_LEN;
    end

    // Writing 0 does not clear; only power loss or auxiliary reset does
    if (wr_remote && reg_wdata[RPTO_REM_POWER_OFF])
      next_power_off = 1'b1;
    // Clear wins: power loss forces the output off at once
    if (!power_lost_b)
      next_power_off = 1'b0;
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      config_reg <= RPTO_CONFIG_RST;
      reset_req  <= RPTO_REMOTE_RST[RPTO_REM_RESET];
      power_off  <= RPTO_REMOTE_RST[RPTO_REM_POWER_OFF];
      trip_a     <= RPTO_TRIP_RST;
      trip_b     <= RPTO_TRIP_RST;
      pulse_cnt  <= '0;
    end
    else
    begin
      config_reg <= next_config_reg;
      reset_req  <= next_reset_req;
      power_off  <= next_power_off;
      trip_a     <= next_trip_a;
      trip_b     <= next_trip_b;
      pulse_cnt  <= next_pulse_cnt;
    end
  end

  // ****************************************
  // Read mux and fan drive
  // ****************************************
  always_comb
  begin
    next_rdata = 8'h00;                       // Unmapped reads return zero
    if (reg_read)
    begin
      unique case (reg_addr)
        RPTO_OFF_CONFIG: next_rdata = config_reg;
        RPTO_OFF_REMOTE:
        begin
          next_rdata[RPTO_REM_RESET]     = reset_req;
          next_rdata[RPTO_REM_POWER_OFF] = power_off;
        end
        RPTO_OFF_TRIP_A: next_rdata = trip_a;
        RPTO_OFF_TRIP_B: next_rdata = trip_b;
        RPTO_OFF_STATUS:
        begin
          next_rdata[RPTO_ST_HOT_A]      = hot[0];
          next_rdata[RPTO_ST_HOT_B]      = hot[1];
          next_rdata[RPTO_ST_FAN_OFF]    = ~config_reg[RPTO_CFG_FAN_RUN];
          next_rdata[RPTO_ST_POWER_LOST] = ~power_lost_b;
        end
        default: next_rdata = 8'h00;
      endcase
    end
    // Fan stops on power loss or on a fan-off request
    if (!power_lost_b || !config_reg[RPTO_CFG_FAN_RUN])
      next_fan_speed = 8'h00;
    else
      next_fan_speed = fan_speed_in;
  end

  // ****************************************
  // Output registers
  // ****************************************
  // Every output is a flop; pins lag their cause by one cycle, but fan speed lags a config write and thermal pins a sample by two
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      reg_rdata         <= 8'h00;
      fan_speed_out     <= 8'h00;
      fan_off_b         <= 1'b1;
      remote_reset_b    <= 1'b1;
      remote_power_off  <= 1'b0;
      overheat_out_a    <= 1'b1;
      overheat_out_b_o  <= 1'b0;
      overheat_out_b_oe <= 1'b0;
    end
    else
    begin
      reg_rdata         <= next_rdata;
      fan_speed_out     <= next_fan_speed;
      fan_off_b         <= next_config_reg[RPTO_CFG_FAN_RUN];
      remote_reset_b    <= ~next_reset_req;
      remote_power_off  <= next_power_off;
      overheat_out_a    <= ~hot[0];
      overheat_out_b_o  <= 1'b0;
      overheat_out_b_oe <= hot[1];
    end
  end

endmodule

// ---- rpto_pkg.sv ----
// Purpose: Shared constants and carriers for the remote power and thermal output block
// Assumes: 250 MHz system clock, 8-bit registers on a plain strobe port
// Notes:   All offsets, field positions, reset values and counts live here
package rpto_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned RPTO_CLOCK_MHZ       = 250;   // System clock rate
  localparam int unsigned RPTO_RESET_PULSE_US  = 125;   // Least low time of remote reset
  // Least time rounds up; exact here
  localparam int unsigned RPTO_RESET_PULSE_CYC = RPTO_RESET_PULSE_US * RPTO_CLOCK_MHZ;
  localparam int unsigned RPTO_PULSE_CNT_W     = 16;    // Wide enough for 31250

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned RPTO_ADDR_W = 4;
  localparam int unsigned RPTO_DATA_W = 8;
  localparam logic [3:0] RPTO_OFF_CONFIG    = 4'h0; // Configuration
  localparam logic [3:0] RPTO_OFF_REMOTE    = 4'h1; // Remote function
  localparam logic [3:0] RPTO_OFF_TRIP_A    = 4'h2; // Trip limit, output A
  localparam logic [3:0] RPTO_OFF_TRIP_B    = 4'h3; // Trip limit, output B
  localparam logic [3:0] RPTO_OFF_STATUS    = 4'h4; // Live output status

  // Field positions
  localparam int unsigned RPTO_CFG_FAN_RUN   = 5;   // 0 requests fan off
  localparam int unsigned RPTO_REM_RESET     = 0;   // Remote reset pulse request
  localparam int unsigned RPTO_REM_POWER_OFF = 1;   // Remote power-off latch
  localparam int unsigned RPTO_ST_HOT_A      = 0;
  localparam int unsigned RPTO_ST_HOT_B      = 1;
  localparam int unsigned RPTO_ST_FAN_OFF    = 2;
  localparam int unsigned RPTO_ST_POWER_LOST = 3;

  // Reset values
  localparam logic [7:0] RPTO_CONFIG_RST = 8'h20;   // Fan run bit set
  localparam logic [7:0] RPTO_REMOTE_RST = 8'h00;
  localparam logic [7:0] RPTO_TRIP_RST   = 8'h64;   // Plain default trip level

  // ****************************************
  // Thermal filter
  // ****************************************
  localparam logic [7:0] RPTO_HYST_DEG   = 8'h05;   // Release margin below trip
  localparam logic [2:0] RPTO_TRIP_RUN   = 3'h4;    // More than three measurements
  localparam logic [2:0] RPTO_CLEAR_RUN  = 3'h3;    // Three measurements

  // One measurement as delivered by the converter
  typedef struct packed
  {
    logic       valid;   // One-cycle strobe
    logic [7:0] temp;    // Degrees Celsius, unsigned
  } rpto_sample_type;

endpackage

// ---- rpto_overheat.sv ----
// Purpose: One overtemperature channel with trip filter and release hysteresis
// Assumes: Samples arrive as one-cycle strobes on the system clock
// Notes:   Same logic serves both thermal outputs
`timescale 1ns/1ps
module rpto_overheat
  import rpto_pkg::*;
(
  input  wire logic            clock,     // System clock
  input  wire logic            rst_b,     // Synchronous reset, low active
  input  wire rpto_sample_type sample,    // Measurement strobe and value
  input  wire logic [7:0]      limit,     // Trip limit
  output logic                 hot        // Registered overtemperature flag
);

  logic       next_hot;            // Next flag value
  logic [2:0] run;                 // Consecutive qualifying measurements
  logic [2:0] next_run;
  logic       above;               // Measurement over the limit
  logic       below;               // Measurement at or under limit minus margin

  // ****************************************
  // Filter next state
  // ****************************************
  always_comb
  begin
    above    = sample.temp > limit;
    // Under the margin nothing counts as cool, so a low limit cannot wrap to a huge release level
    below    = (limit < RPTO_HYST_DEG) ? 1'b0 : (sample.temp <= (limit - RPTO_HYST_DEG));
    next_hot = hot;
    next_run = run;
    if (sample.valid)
    begin
      if (!hot)
      begin
        // Count runs of over-limit results
        if (above)
        begin
          if (run + 3'h1 >= RPTO_TRIP_RUN)
          begin
            next_hot = 1'b1;
            next_run = 3'h0;
          end
          else
            next_run = run + 3'h1;
        end
        else
          next_run = 3'h0;
      end
      else
      begin
        // Count runs of cool results
        if (below)
        begin
          if (run + 3'h1 >= RPTO_CLEAR_RUN)
          begin
            next_hot = 1'b0;
            next_run = 3'h0;
          end
          else
            next_run = run + 3'h1;
        end
        else
          next_run = 3'h0;
      end
    end
  end

  // ****************************************
  // Filter registers
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      hot <= 1'b0;
      run <= 3'h0;
    end
    else
    begin
      hot <= next_hot;
      run <= next_run;
    end
  end

endmodule

// ---- rpto_top_assertions.sv ----
// Purpose: Port checks for the remote power and thermal output block
// Assumes: One clock, synchronous low reset on auxiliary_reset_in
// Notes:   Bound to rpto_top from the bench top file
`timescale 1ns/1ps
module rpto_top_assertions
  import rpto_pkg::*;
(
  input wire logic            clock,
  input wire logic            auxiliary_reset_in,
  input wire logic [3:0]      reg_addr,
  input wire logic [7:0]      reg_wdata,
  input wire logic            reg_write,
  input wire logic            reg_read,
  input wire logic [7:0]      reg_rdata,
  input wire logic            power_lost_b,
  input wire rpto_sample_type sample,
  input wire logic [7:0]      fan_speed_in,
  input wire logic [7:0]      fan_speed_out,
  input wire logic            fan_off_b,
  input wire logic            remote_reset_b,
  input wire logic            remote_power_off,
  input wire logic            overheat_out_a,
  input wire logic            overheat_out_b_o,
  input wire logic            overheat_out_b_oe
);
  // ****************************************
  // Helper and properties
  // ****************************************
  logic [15:0] low_cnt;  // Low cycles of the remote reset pin
  // Counter, since a plain delay cannot span the whole pulse
  always_ff @(posedge clock)
  begin
    if (!auxiliary_reset_in || remote_reset_b)
      low_cnt <= 16'h0000;
    else
      low_cnt <= low_cnt + 16'h0001;
  end
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!auxiliary_reset_in);
  a_fan_follow: assert property (
    reg_write && reg_addr == RPTO_OFF_CONFIG |=> fan_off_b == $past(reg_wdata[5]))
    else $error("fan off pin does not follow config write");
  a_fan_gate: assert property (
    !fan_off_b |=> fan_speed_out == 8'h00)
    else $error("fan speed driven while fan off requested");
  a_speed_pass: assert property (
    power_lost_b && fan_off_b && !reg_write |=> fan_speed_out == $past(fan_speed_in))
    else $error("fan speed not passed through");
  a_pulse_start: assert property (
    reg_write && reg_addr == RPTO_OFF_REMOTE && reg_wdata[0] && remote_reset_b
    |=> !remote_reset_b)
    else $error("remote reset pulse did not start");
  a_pulse_len: assert property (
    $past(auxiliary_reset_in) && $rose(remote_reset_b) |-> low_cnt == 16'(RPTO_RESET_PULSE_CYC))
    else $error("remote reset pulse length wrong");
  a_bit_read: assert property (
    reg_read && reg_addr == RPTO_OFF_REMOTE |=> reg_rdata[0] == !$past(remote_reset_b))
    else $error("remote reset bit disagrees with pin");
  a_off_set: assert property (
    reg_write && reg_addr == RPTO_OFF_REMOTE && reg_wdata[1] && power_lost_b
    |=> remote_power_off)
    else $error("power-off did not latch");
  a_off_hold: assert property (
    remote_power_off && power_lost_b |=> remote_power_off)
    else $error("power-off cleared without power loss");
  a_off_lost: assert property (
    !power_lost_b |=> !remote_power_off && fan_speed_out == 8'h00)
    else $error("power loss did not clear outputs");
  a_hot_cause: assert property (
    $past(auxiliary_reset_in) && ($changed(overheat_out_a) || $changed(overheat_out_b_oe))
    |-> $past(sample.valid, 2))
    else $error("thermal output moved without a sample");
  a_od_data: assert property (
    overheat_out_b_o == 1'b0)
    else $error("open drain data not low");
endmodule

// ---- rpto_power_model.sv ----
// Purpose: System power sequencer on the far side of the block
// Assumes: Bench requests power loss and auxiliary reset
// Notes:   Pins move just after a clock edge
`timescale 1ns/1ps
module rpto_power_model
(
  input  wire logic clock,         // System clock
  input  wire logic cut_req,       // Ask for main power loss
  input  wire logic aux_req,       // Ask for auxiliary reset
  output logic      power_lost_b,  // Low while main power gone
  output logic      aux_reset_b    // Low while reset held
);
  // ****************************************
  // Drives
  // ****************************************
  // Reset held from time zero so the block starts clean
  logic lost_q = 1'b1;  // Main power present at start
  logic aux_q  = 1'b0;  // Reset asserted at start
  assign power_lost_b = lost_q;
  assign aux_reset_b  = aux_q;
  // Registered so the levels never race the sampling edge
  always @(posedge clock)
  begin
    lost_q <= !cut_req;
    aux_q  <= !aux_req;
  end
endmodule

// ---- rpto_top_tb.sv ----
// Purpose: Self-checking bench for rpto_top
// Assumes: 250 MHz clock, power model drives reset and power loss
// Notes:   One task per scenario
`timescale 1ns/1ps
module rpto_top_tb
  import rpto_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic            clock      = 1'b0;
  logic            aux_req    = 1'b1;
  logic            cut_req    = 1'b0;
  logic [3:0]      reg_addr   = 4'h0;
  logic [7:0]      reg_wdata  = 8'h00;
  logic            reg_write  = 1'b0;
  logic            reg_read   = 1'b0;
  rpto_sample_type sample     = '0;
  logic [7:0]      fan_speed_in = 8'h5A;
  logic            auxiliary_reset_in;
  logic            power_lost_b;
  logic [7:0]      reg_rdata;
  logic [7:0]      fan_speed_out;
  logic            fan_off_b;
  logic            remote_reset_b;
  logic            remote_power_off;
  logic            overheat_out_a;
  logic            overheat_out_b_o;
  logic            overheat_out_b_oe;
  int              failures   = 0;
  int              n_compared = 0;
  int              cyc        = 0;
  // Temperatures around a limit of 0x50 and the hot flag after each
  logic [7:0]      tt [14] = '{8'h51, 8'h51, 8'h51, 8'h50, 8'h51, 8'h51, 8'h51,
                               8'h51, 8'h4B, 8'h4B, 8'h4C, 8'h4B, 8'h4B, 8'h4B};
  logic [13:0]     hot_mask = 14'b01111110000000;
  always #2 clock = ~clock;
  rpto_power_model pwr (.clock, .cut_req, .aux_req, .power_lost_b,
                        .aux_reset_b(auxiliary_reset_in));
  rpto_top uut (.clock, .auxiliary_reset_in, .reg_addr, .reg_wdata, .reg_write,
                .reg_read, .reg_rdata, .power_lost_b, .sample, .fan_speed_in,
                .fan_speed_out, .fan_off_b, .remote_reset_b, .remote_power_off,
                .overheat_out_a, .overheat_out_b_o, .overheat_out_b_oe);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim();
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Settle just past an edge
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    cmp8(reg_rdata, e);
  endtask
  task automatic t_defaults();
    wr(4'hF, 8'hFF);
    wr(RPTO_OFF_STATUS, 8'hFF);
    rd(RPTO_OFF_CONFIG, RPTO_CONFIG_RST);
    rd(RPTO_OFF_REMOTE, RPTO_REMOTE_RST);
    rd(RPTO_OFF_TRIP_A, RPTO_TRIP_RST);
    rd(RPTO_OFF_TRIP_B, RPTO_TRIP_RST);
    rd(RPTO_OFF_STATUS, 8'h00);
    rd(4'hF, 8'h00);
    cmp8({4'h0, fan_off_b, remote_reset_b, remote_power_off, overheat_out_a}, 8'h0D);
  endtask
  task automatic t_fan();
    // New speed code so a stuck passthrough cannot match
    @(posedge clock);
    fan_speed_in <= 8'hC3;
    wr(RPTO_OFF_CONFIG, 8'h00);
    cmp8({7'h00, fan_off_b}, 8'h00);
    tick();
    cmp8(fan_speed_out, 8'h00);
    rd(RPTO_OFF_STATUS, 8'h04);
    wr(RPTO_OFF_CONFIG, RPTO_CONFIG_RST);
    cmp8({7'h00, fan_off_b}, 8'h01);
    tick();
    cmp8(fan_speed_out, fan_speed_in);
  endtask
  task automatic t_pulse();
    int n;
    wr(RPTO_OFF_REMOTE, 8'h01);
    cmp8({7'h00, remote_reset_b}, 8'h00);
    rd(RPTO_OFF_REMOTE, 8'h01);
    wr(RPTO_OFF_REMOTE, 8'h01);
    n = 4;  // Edges used by the read and the ignored rewrite
    while (!remote_reset_b && n < 40000)
    begin
      tick();
      n++;
    end
    cmp16(n[15:0], 16'(RPTO_RESET_PULSE_CYC));
    rd(RPTO_OFF_REMOTE, 8'h00);
  endtask
  task automatic t_power();
    wr(RPTO_OFF_REMOTE, 8'h02);
    cmp8({7'h00, remote_power_off}, 8'h01);
    wr(RPTO_OFF_REMOTE, 8'h00);
    cmp8({7'h00, remote_power_off}, 8'h01);
    @(posedge clock);
    cut_req <= 1'b1;
    repeat (3) tick();
    cmp8({remote_power_off, fan_speed_out[6:0]}, 8'h00);
    cmp8(fan_speed_out, 8'h00);
    rd(RPTO_OFF_STATUS, 8'h08);
    @(posedge clock);
    cut_req <= 1'b0;
    repeat (2) tick();
    wr(RPTO_OFF_REMOTE, 8'h02);
    wr(RPTO_OFF_CONFIG, 8'h00);
    @(posedge clock);
    aux_req <= 1'b1;
    @(posedge clock);
    aux_req <= 1'b0;
    repeat (2) tick();
    cmp8({6'h00, remote_power_off, fan_off_b}, 8'h01);
    rd(RPTO_OFF_CONFIG, RPTO_CONFIG_RST);
  endtask
  // Limits chosen so only one channel can trip; e is {b, a}
  task automatic t_overheat_trip_limit(input logic [7:0] la, input logic [7:0] lb, input logic [1:0] e);
    wr(RPTO_OFF_TRIP_A, la);
    wr(RPTO_OFF_TRIP_B, lb);
    for (int i = 0; i < 14; i++)
    begin
      @(posedge clock);
      sample <= '{valid: 1'b1, temp: tt[i]};
      @(posedge clock);
      sample.valid <= 1'b0;
      tick();
      cmp8({6'h00, overheat_out_b_oe, ~overheat_out_a}, hot_mask[i] ? {6'h00, e} : 8'h00);
      if (i == 7)
        rd(RPTO_OFF_STATUS, {6'h00, e});
    end
  endtask
  // ****************************************
  // Main sequence and timeout
  // ****************************************
  initial
  begin
    // Model lags one edge, so the block sees two reset edges
    repeat (1) @(posedge clock);
    aux_req <= 1'b0;
    repeat (2) @(posedge clock);
    t_defaults();
    t_fan();
    t_pulse();
    t_power();
    t_overheat_trip_limit(8'h50, 8'hF0, 2'b01);
    t_overheat_trip_limit(8'hF0, 8'h50, 2'b10);
    end_sim();
  end
  // Whole run is near 31400 cycles; a hang is cut well after
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      end_sim();
    end
  end
endmodule
bind rpto_top rpto_top_assertions chk (.clock, .auxiliary_reset_in, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .power_lost_b, .sample, .fan_speed_in, .fan_speed_out,
  .fan_off_b, .remote_reset_b, .remote_power_off, .overheat_out_a, .overheat_out_b_o,
  .overheat_out_b_oe);
